// file: csw_pkg.sv
// Purpose: constants for the chip-select and wait-state unit
// Assumes: 20-bit physical address, 16-bit control registers
// Notes:   register indices and field layouts are shared with the tests
package csw_pkg;
  // register indices on the plain register port
  localparam logic [2:0] REG_UPPER_MEMORY_SELECT_CTRL = 3'h0;
  localparam logic [2:0] REG_LOW_MEMORY_SELECT_CTRL = 3'h1;
  localparam logic [2:0] REG_MIDRANGE_MEMORY_SELECT_CTRL = 3'h2;
  localparam logic [2:0] REG_PERIPHERAL_SELECT_BASE_CTRL = 3'h3;
  localparam logic [2:0] REG_SELECT_AUXILIARY_CTRL = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;
  // wait and ready fields common to all select registers; XW_BIT is used by the peripheral base only
  localparam int W_LO    = 0;
  localparam int W_HI    = 1;
  localparam int RDY_BIT = 2;
  localparam int XW_BIT  = 3;
  // upper and low select fields
  localparam int PSRAM_BIT = 6;
  localparam int DA_BIT    = 7;
  localparam int BND_LO    = 12;
  localparam int BND_HI    = 15;
  // midrange base and auxiliary fields
  localparam int MB_LO  = 9;
  localparam int MB_HI  = 15;
  localparam int SZ_LO  = 8;
  localparam int SZ_HI  = 10;
  localparam int IO_BIT = 6;
  localparam int AO_BIT = 7;
  // peripheral base field (address bits 19..11)
  localparam int PB_LO = 7;
  localparam int PB_HI = 15;
  localparam logic [15:0] UPPER_MEMORY_SELECT_CTRL_RST = 16'hF007;
  localparam logic [15:0] REG_RST  = 16'h0000;
  localparam logic [4:0]  MCS_SH0  = 5'h0D;
  localparam logic [4:0]  MCS_QSH  = 5'h02;
  localparam logic [3:0]  EXTRA_W  = 4'h2;
  // source indices for wait and ready combining
  localparam int S_U   = 0;
  localparam int S_L   = 1;
  localparam int S_M0  = 2;
  localparam int S_P0  = 6;
  localparam int S_P4  = 10;
  localparam int S_P5  = 11;
  localparam int S_P6  = 12;
  localparam int S_PCB = 13;
  localparam int NSRC  = 14;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_TR, ST_TX, ST_T4
  } csw_state_type;
  // three-bit wait code of the five lowest peripheral selects
  function automatic logic [3:0] csw_xwait(input logic [2:0] code);
    case (code)
      3'h4:    csw_xwait = 4'h5;
      3'h5:    csw_xwait = 4'h7;
      3'h6:    csw_xwait = 4'h9;
      3'h7:    csw_xwait = 4'hF;
      default: csw_xwait = {2'h0, code[1:0]};
    endcase
  endfunction
endpackage

// file: csw_select_unit.sv
// Purpose: chip selects, byte write strobes and wait-state timing
// Assumes: one access at a time, started by a one-cycle cycleStart
// Notes:   resolution is one mclk; half-cycle skews are not modelled
//
// Contract
// - byte strobes are OR of enable and write
// - byte strobes timed with the write strobe
// - address held T1-T4, muxed bus T1 only
// - PSRAM only in programmed low select region
// - selects assert for CPU and DMA cycles
// - six memory and seven peripheral selects, one without a pin
// - register write enables decode despite pin use
// - upper and low selects follow address bus
// - bit 2 requests external ready
// - bits 1..0 give 0 to 3 waits
// - low peripheral selects add 5,7,9,15 waits
// - programmed waits finish before ready counts
// - ready sampled first wait, else two extra
// - internal block select: no waits, no ready
// - disable-address bit blanks muxed address
// - wait settings apply even as general I/O
// - fifth peripheral select keeps wait logic
// - address-mode pins lose wait logic
// - latched address bits 1,2 on shared pins
// - fetch starts with upper select, three waits
// - upper select resets to top 64K, ready
// - low select active after register touch
// - peripheral selects need base and aux touch
// - midrange selects need base and aux touch
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
module csw_select_unit (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // access request from the bus sequencer
  input  wire logic        cycleStart,
  input  wire logic [19:0] cycleAddr,
  input  wire logic        cycleIo,
  input  wire logic        cycleWrite,
  input  wire logic        cycleBheN,
  input  wire logic        pcbHit,
  // ready pins
  input  wire logic        ardy,
  input  wire logic        srdy,
  // external bus
  output logic [19:0]      addrBus,
  output logic [15:0]      adAddrOut,
  output logic             adAddrOe,
  output logic             wrN,
  output logic             whbN,
  output logic             wlbN,
  // select pins
  output logic             ucsN,
  output logic             lcsN,
  output logic [3:0]       mcsN,
  output logic [3:0]       pcsLowN,
  output logic             pcs5Pin,
  output logic             pcs6Pin,
  output logic             psramSel,
  // status to the sequencer
  output logic             busy,
  output logic             cycleDone
);

  // control registers
  logic [15:0] upper_memory_select_ctrl_ff;
  logic [15:0] low_memory_select_ctrl_ff;
  logic [15:0] midrange_memory_select_ctrl_ff;
  logic [15:0] peripheral_select_base_ctrl_ff;
  logic [15:0] select_auxiliary_ctrl_ff;
  logic        lcsEn_ff;
  logic        mmcsSeen_ff;
  logic        pacsSeen_ff;
  logic        mpcsSeen_ff;
  logic [15:0] regRdata_ff;
  logic [15:0] nxt_regRdata;

  wire regAcc = regWr | regRd;
  wire hitUr  = regAddr == csw_pkg::REG_UPPER_MEMORY_SELECT_CTRL;
  wire hitLr  = regAddr == csw_pkg::REG_LOW_MEMORY_SELECT_CTRL;
  wire hitMr  = regAddr == csw_pkg::REG_MIDRANGE_MEMORY_SELECT_CTRL;
  wire hitPr  = regAddr == csw_pkg::REG_PERIPHERAL_SELECT_BASE_CTRL;
  wire hitAr  = regAddr == csw_pkg::REG_SELECT_AUXILIARY_CTRL;
  wire hitSr  = regAddr == csw_pkg::REG_STAT;

  // a write enables decode whatever the pin is used for
  wire mcsEn = mmcsSeen_ff & mpcsSeen_ff;
  wire pcsEn = pacsSeen_ff & mpcsSeen_ff;
  wire addrMode = select_auxiliary_ctrl_ff[csw_pkg::AO_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upper_memory_select_ctrl_ff <= csw_pkg::UPPER_MEMORY_SELECT_CTRL_RST;
      low_memory_select_ctrl_ff <= csw_pkg::REG_RST;
      midrange_memory_select_ctrl_ff <= csw_pkg::REG_RST;
      peripheral_select_base_ctrl_ff <= csw_pkg::REG_RST;
      select_auxiliary_ctrl_ff <= csw_pkg::REG_RST;
    end else if (regWr) begin
      if (hitUr) upper_memory_select_ctrl_ff <= regWdata;
      if (hitLr) low_memory_select_ctrl_ff <= regWdata;
      if (hitMr) midrange_memory_select_ctrl_ff <= regWdata;
      if (hitPr) peripheral_select_base_ctrl_ff <= regWdata;
      if (hitAr) select_auxiliary_ctrl_ff <= regWdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lcsEn_ff    <= 1'b0;
      mmcsSeen_ff <= 1'b0;
      pacsSeen_ff <= 1'b0;
      mpcsSeen_ff <= 1'b0;
    end else if (regAcc) begin
      if (hitLr) lcsEn_ff <= 1'b1;
      if (hitMr) mmcsSeen_ff <= 1'b1;
      if (hitPr) pacsSeen_ff <= 1'b1;
      if (hitAr) mpcsSeen_ff <= 1'b1;
    end
  end

  csw_pkg::csw_state_type state_ff;
  csw_pkg::csw_state_type nxt_state;

  wire [15:0] statWord = {11'h000, busy, pcsEn, mcsEn, lcsEn_ff, 1'b1};

  always_comb begin
    nxt_regRdata = 16'h0000;
    if (regRd) begin
      case (regAddr)
        csw_pkg::REG_UPPER_MEMORY_SELECT_CTRL: nxt_regRdata = upper_memory_select_ctrl_ff;
        csw_pkg::REG_LOW_MEMORY_SELECT_CTRL: nxt_regRdata = low_memory_select_ctrl_ff;
        csw_pkg::REG_MIDRANGE_MEMORY_SELECT_CTRL: nxt_regRdata = midrange_memory_select_ctrl_ff;
        csw_pkg::REG_PERIPHERAL_SELECT_BASE_CTRL: nxt_regRdata = peripheral_select_base_ctrl_ff;
        csw_pkg::REG_SELECT_AUXILIARY_CTRL: nxt_regRdata = select_auxiliary_ctrl_ff;
        csw_pkg::REG_STAT: nxt_regRdata = statWord;
        default:           nxt_regRdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) regRdata_ff <= 16'h0000;
    else     regRdata_ff <= nxt_regRdata;
  end
  assign regRdata = regRdata_ff;

  // ready pins: three stages, level taken when the last two agree
  logic [1:0] rdyS1_ff;
  logic [1:0] rdyS2_ff;
  logic [1:0] rdyS3_ff;
  logic [1:0] rdyLvl_ff;
  wire  [1:0] rdyPin = {srdy, ardy};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gSync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          rdyS1_ff[g]  <= 1'b0;
          rdyS2_ff[g]  <= 1'b0;
          rdyS3_ff[g]  <= 1'b0;
          rdyLvl_ff[g] <= 1'b0;
        end else begin
          rdyS1_ff[g] <= rdyPin[g];
          rdyS2_ff[g] <= rdyS1_ff[g];
          rdyS3_ff[g] <= rdyS2_ff[g];
          if (rdyS2_ff[g] == rdyS3_ff[g]) rdyLvl_ff[g] <= rdyS3_ff[g];
        end
      end
    end
  endgenerate
  wire rdyNow = |rdyLvl_ff;

  // region decode, same for CPU and DMA cycles
  wire memCyc = ~cycleIo;
  wire [3:0] aTop = cycleAddr[19:16];
  wire uHit = memCyc & (aTop >= upper_memory_select_ctrl_ff[csw_pkg::BND_HI:csw_pkg::BND_LO]);
  wire lHit = memCyc & lcsEn_ff &
              (aTop <= low_memory_select_ctrl_ff[csw_pkg::BND_HI:csw_pkg::BND_LO]);
  wire [19:0] mBase = {midrange_memory_select_ctrl_ff[csw_pkg::MB_HI:csw_pkg::MB_LO], 13'h0000};
  wire [19:0] mOff  = cycleAddr - mBase;
  wire [4:0]  mSh   = csw_pkg::MCS_SH0 + {2'h0, select_auxiliary_ctrl_ff[csw_pkg::SZ_HI:csw_pkg::SZ_LO]};
  wire [19:0] mOver = mOff >> mSh;
  wire [19:0] mQuar = mOff >> (mSh - csw_pkg::MCS_QSH);
  wire mIn = memCyc & mcsEn & (cycleAddr >= mBase) & (mOver == 20'h00000);
  wire [1:0] mIdx = mQuar[1:0];
  wire pIoSp  = select_auxiliary_ctrl_ff[csw_pkg::IO_BIT];
  wire [8:0] pBase = peripheral_select_base_ctrl_ff[csw_pkg::PB_HI:csw_pkg::PB_LO];
  // in I/O space only the low 64K is decoded
  wire pWinIo  = cycleIo & (aTop == 4'h0) & (cycleAddr[15:11] == pBase[4:0]);
  wire pWinMem = memCyc & (cycleAddr[19:11] == pBase);
  wire pIn  = pcsEn & (pIoSp ? pWinIo : pWinMem);
  wire [2:0] pIdx = cycleAddr[10:8];

  // per-source hit, wait count and ready need
  logic [csw_pkg::NSRC-1:0] srcHit;
  logic [3:0]               srcWait [csw_pkg::NSRC];
  logic [csw_pkg::NSRC-1:0] srcRdy;

  wire [3:0] uW = {2'h0, upper_memory_select_ctrl_ff[csw_pkg::W_HI:csw_pkg::W_LO]};
  wire [3:0] lW = {2'h0, low_memory_select_ctrl_ff[csw_pkg::W_HI:csw_pkg::W_LO]};
  wire [3:0] mW = {2'h0, midrange_memory_select_ctrl_ff[csw_pkg::W_HI:csw_pkg::W_LO]};
  wire [3:0] aW = {2'h0, select_auxiliary_ctrl_ff[csw_pkg::W_HI:csw_pkg::W_LO]};
  wire [2:0] pCode = {peripheral_select_base_ctrl_ff[csw_pkg::XW_BIT], peripheral_select_base_ctrl_ff[csw_pkg::W_HI:csw_pkg::W_LO]};
  wire [3:0] pW = csw_pkg::csw_xwait(pCode);

  assign srcHit[csw_pkg::S_U]   = uHit;
  assign srcHit[csw_pkg::S_L]   = lHit;
  assign srcHit[csw_pkg::S_PCB] = pcbHit;
  assign srcWait[csw_pkg::S_U]   = uW;
  assign srcWait[csw_pkg::S_L]   = lW;
  assign srcWait[csw_pkg::S_PCB] = 4'h0;
  assign srcRdy[csw_pkg::S_U]   = upper_memory_select_ctrl_ff[csw_pkg::RDY_BIT];
  assign srcRdy[csw_pkg::S_L]   = low_memory_select_ctrl_ff[csw_pkg::RDY_BIT];
  assign srcRdy[csw_pkg::S_PCB] = 1'b0;

  // wait logic stays live whether or not the pin is a select, except indices 5 and 6, which lose it in address mode
  generate
    for (g = 0; g < 4; g++) begin : gMcs
      assign srcHit[csw_pkg::S_M0+g]  = mIn & (mIdx == 2'(g));
      assign srcWait[csw_pkg::S_M0+g] = mW;
      assign srcRdy[csw_pkg::S_M0+g]  = midrange_memory_select_ctrl_ff[csw_pkg::RDY_BIT];
    end
    for (g = 0; g < 7; g++) begin : gPcs
      // index 4 has no pin but still stretches cycles
      localparam bit HI = (g >= 5);
      wire live = HI ? ~addrMode : 1'b1;
      assign srcHit[csw_pkg::S_P0+g]  = pIn & live & (pIdx == 3'(g));
      assign srcWait[csw_pkg::S_P0+g] = HI ? aW : pW;
      assign srcRdy[csw_pkg::S_P0+g]  = HI ? select_auxiliary_ctrl_ff[csw_pkg::RDY_BIT]
                                           : peripheral_select_base_ctrl_ff[csw_pkg::RDY_BIT];
    end
  endgenerate

  // overlapping selects should agree; the longest wins if not
  logic [3:0] accWait;
  logic       accRdy;
  always_comb begin
    accWait = 4'h0;
    accRdy  = 1'b0;
    for (int i = 0; i < csw_pkg::NSRC; i++) begin
      if (srcHit[i]) begin
        accRdy = accRdy | srcRdy[i];
        if (srcWait[i] > accWait) accWait = srcWait[i];
      end
    end
  end

  // cycle sequencing
  logic [3:0] waitCnt_ff;
  logic [3:0] nxt_waitCnt;
  logic       needRdy_ff;
  logic       firstW_ff;
  logic       rdySeen_ff;
  logic       isWrite_ff;

  always_comb begin
    nxt_state   = state_ff;
    nxt_waitCnt = waitCnt_ff;
    case (state_ff)
      csw_pkg::ST_IDLE: begin
        if (cycleStart) begin
          nxt_state   = csw_pkg::ST_T1;
          nxt_waitCnt = accWait;
        end
      end
      csw_pkg::ST_T1: nxt_state = csw_pkg::ST_T2;
      csw_pkg::ST_T2: nxt_state = csw_pkg::ST_T3;
      csw_pkg::ST_T3: begin
        if (waitCnt_ff != 4'h0)          nxt_state = csw_pkg::ST_TW;
        else if (needRdy_ff && !rdyNow)  nxt_state = csw_pkg::ST_TR;
        else                             nxt_state = csw_pkg::ST_T4;
      end
      csw_pkg::ST_TW: begin
        nxt_waitCnt = waitCnt_ff - 4'h1;
        if (waitCnt_ff == 4'h1) begin
          if (!needRdy_ff || rdySeen_ff || (firstW_ff && rdyNow))
            nxt_state = csw_pkg::ST_T4;
          else
            nxt_state = csw_pkg::ST_TR;
        end
      end
      csw_pkg::ST_TR: begin
        if (rdyNow) begin
          nxt_state   = csw_pkg::ST_TX;
          nxt_waitCnt = csw_pkg::EXTRA_W;
        end
      end
      csw_pkg::ST_TX: begin
        nxt_waitCnt = waitCnt_ff - 4'h1;
        if (waitCnt_ff == 4'h1) nxt_state = csw_pkg::ST_T4;
      end
      csw_pkg::ST_T4: nxt_state = csw_pkg::ST_IDLE;
      default:        nxt_state = csw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff   <= csw_pkg::ST_IDLE;
      waitCnt_ff <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      waitCnt_ff <= nxt_waitCnt;
    end
  end

  // ready is looked at in the first wait cycle only
  wire startNow = (state_ff == csw_pkg::ST_IDLE) & cycleStart;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      needRdy_ff <= 1'b0;
      firstW_ff  <= 1'b0;
      rdySeen_ff <= 1'b0;
      isWrite_ff <= 1'b0;
    end else if (startNow) begin
      needRdy_ff <= accRdy;
      firstW_ff  <= 1'b1;
      rdySeen_ff <= 1'b0;
      isWrite_ff <= cycleWrite;
    end else if (state_ff == csw_pkg::ST_TW) begin
      firstW_ff <= 1'b0;
      if (firstW_ff) rdySeen_ff <= rdyNow;
    end
  end

  // pin registers
  logic [19:0] addrBus_ff;
  logic [15:0] adAddrOut_ff;
  logic        adAddrOe_ff;
  logic        wrN_ff;
  logic        whbN_ff;
  logic        wlbN_ff;
  logic        bheN_ff;
  logic        ucsN_ff;
  logic        lcsN_ff;
  logic [3:0]  mcsN_ff;
  logic [3:0]  pcsLowN_ff;
  logic        pcs5Pin_ff;
  logic        pcs6Pin_ff;
  logic        psramSel_ff;
  logic        busy_ff;
  logic        cycleDone_ff;

  wire nxtIdle = nxt_state == csw_pkg::ST_IDLE;
  wire nxtWrOn = ~nxtIdle & (nxt_state != csw_pkg::ST_T1) &
                 (nxt_state != csw_pkg::ST_T4);
  wire nxtWrite = startNow ? cycleWrite : isWrite_ff;
  wire nxt_wrN  = ~(nxtWrite & nxtWrOn);
  wire nxtBheN  = startNow ? cycleBheN : bheN_ff;
  wire nxtA0    = startNow ? cycleAddr[0] : addrBus_ff[0];
  wire daBlock  = (uHit & upper_memory_select_ctrl_ff[csw_pkg::DA_BIT]) |
                  (lHit & low_memory_select_ctrl_ff[csw_pkg::DA_BIT]);
  wire [3:0] mHitV = srcHit[csw_pkg::S_P0-1:csw_pkg::S_M0];
  wire [3:0] pHitV = srcHit[csw_pkg::S_P4-1:csw_pkg::S_P0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addrBus_ff   <= 20'h00000;
      adAddrOut_ff <= 16'h0000;
      adAddrOe_ff  <= 1'b0;
      bheN_ff      <= 1'b1;
    end else begin
      if (startNow) begin
        addrBus_ff   <= cycleAddr;
        adAddrOut_ff <= cycleAddr[15:0];
        bheN_ff      <= cycleBheN;
      end
      adAddrOe_ff <= startNow & ~daBlock;
    end
  end

  // byte strobes move with the write strobe from the held address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrN_ff  <= 1'b1;
      whbN_ff <= 1'b1;
      wlbN_ff <= 1'b1;
    end else begin
      wrN_ff  <= nxt_wrN;
      whbN_ff <= nxtBheN | nxt_wrN;
      wlbN_ff <= nxtA0 | nxt_wrN;
    end
  end

  // selects asserted from T1 through T4, with the address bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ucsN_ff     <= 1'b1;
      lcsN_ff     <= 1'b1;
      mcsN_ff     <= 4'hF;
      pcsLowN_ff  <= 4'hF;
      psramSel_ff <= 1'b0;
    end else if (startNow) begin
      ucsN_ff     <= ~uHit;
      lcsN_ff     <= ~lHit;
      mcsN_ff     <= ~mHitV;
      pcsLowN_ff  <= ~pHitV;
      psramSel_ff <= lHit & low_memory_select_ctrl_ff[csw_pkg::PSRAM_BIT];
    end else if (nxtIdle) begin
      ucsN_ff     <= 1'b1;
      lcsN_ff     <= 1'b1;
      mcsN_ff     <= 4'hF;
      pcsLowN_ff  <= 4'hF;
      psramSel_ff <= 1'b0;
    end
  end

  // shared pins: latched address bits or active-low selects
  wire nxtP5 = addrMode ? (startNow ? cycleAddr[1] : pcs5Pin_ff)
                        : (startNow ? ~srcHit[csw_pkg::S_P5]
                                    : (nxtIdle | pcs5Pin_ff));
  wire nxtP6 = addrMode ? (startNow ? cycleAddr[2] : pcs6Pin_ff)
                        : (startNow ? ~srcHit[csw_pkg::S_P6]
                                    : (nxtIdle | pcs6Pin_ff));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcs5Pin_ff <= 1'b1;
      pcs6Pin_ff <= 1'b1;
    end else begin
      pcs5Pin_ff <= nxtP5;
      pcs6Pin_ff <= nxtP6;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_ff      <= 1'b0;
      cycleDone_ff <= 1'b0;
    end else begin
      busy_ff      <= ~nxtIdle;
      cycleDone_ff <= nxt_state == csw_pkg::ST_T4;
    end
  end

  assign busy      = busy_ff;
  assign cycleDone = cycleDone_ff;
  assign addrBus   = addrBus_ff;
  assign adAddrOut = adAddrOut_ff;
  assign adAddrOe  = adAddrOe_ff;
  assign wrN       = wrN_ff;
  assign whbN      = whbN_ff;
  assign wlbN      = wlbN_ff;
  assign ucsN      = ucsN_ff;
  assign lcsN      = lcsN_ff;
  assign mcsN      = mcsN_ff;
  assign pcsLowN   = pcsLowN_ff;
  assign pcs5Pin   = pcs5Pin_ff;
  assign pcs6Pin   = pcs6Pin_ff;
  assign psramSel  = psramSel_ff;

endmodule // csw_select_unit

// file: csw_select_unit_properties.sv
// Purpose: port-level timing properties of the select unit
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   byte strobes are checked against the held address and latched enable
`timescale 1ns/100ps
module csw_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // access request
  input wire logic        cycleStart,
  input wire logic [19:0] cycleAddr,
  input wire logic        cycleBheN,
  // bus and selects
  input wire logic [19:0] addrBus,
  input wire logic        adAddrOe,
  input wire logic        wrN,
  input wire logic        whbN,
  input wire logic        wlbN,
  input wire logic        ucsN,
  input wire logic        lcsN,
  input wire logic [3:0]  mcsN,
  input wire logic [3:0]  pcsLowN,
  input wire logic        psramSel,
  input wire logic        busy,
  input wire logic        cycleDone
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic            bheLat_ff;
  wire logic       take   = cycleStart && !busy;
  wire logic       inBody = busy && !cycleDone;
  wire logic [9:0] selAll = {ucsN, lcsN, mcsN, pcsLowN};
  // the enable is only visible with the start pulse, so keep a copy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      bheLat_ff <= 1'b1;
    else if (take)
      bheLat_ff <= cycleBheN;
  end
  sequence s_take;
    take;
  endsequence
  sequence s_base;
    !cycleDone [*3];
  endsequence
  a_addr_load: assert property (s_take |=> busy && addrBus == $past(cycleAddr))
    else $error("address not loaded in T1");
  a_addr_held: assert property (busy && $past(inBody) |-> $stable(addrBus))
    else $error("address moved inside cycle");
  a_oe_first: assert property (adAddrOe |-> $rose(busy))
    else $error("muxed address outside T1");
  a_base_len: assert property ($rose(busy) |-> s_base)
    else $error("cycle shorter than four clocks");
  a_done_bound: assert property (s_take |=> ##[3:200] cycleDone)
    else $error("cycle never reached T4");
  a_sel_steady: assert property (busy && $past(inBody) |-> $stable(selAll))
    else $error("select changed inside cycle");
  a_sel_idle: assert property (!busy |-> &selAll)
    else $error("select low while idle");
  a_wr_window: assert property (!wrN |-> inBody && !adAddrOe)
    else $error("write strobe outside T2 to T3");
  a_high_strobe: assert property (whbN == (bheLat_ff | wrN))
    else $error("high byte strobe wrong");
  a_low_strobe: assert property (wlbN == (addrBus[0] | wrN))
    else $error("low byte strobe wrong");
  a_psram_low: assert property (psramSel |-> !lcsN)
    else $error("psram outside low select");
endmodule // csw_props
bind csw_select_unit csw_props csw_props_inst (.mclk, .rst, .cycleStart, .cycleAddr,
  .cycleBheN, .addrBus, .adAddrOe, .wrN, .whbN, .wlbN, .ucsN, .lcsN, .mcsN, .pcsLowN,
  .psramSel, .busy, .cycleDone);

// file: csw_mem_model.sv
// Purpose: far-side memory and peripheral ready responder
// Assumes: slowCyc of 0 means ready always high
// Notes:   with slowCyc nonzero, ready drops between accesses so a stale ready never ends a cycle
`timescale 1ns/100ps
module csw_mem_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // selects seen on the bus
  input  wire logic [9:0] selN,
  // behaviour control
  input  wire logic [4:0] slowCyc,
  input  wire logic       useSync,
  // ready pins
  output logic            ardy,
  output logic            srdy
);
  logic [4:0] cnt_ff;
  wire logic  hit = !(&selN);
  wire logic  rdy = (slowCyc == 5'h00) || (hit && cnt_ff >= slowCyc);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      cnt_ff <= 5'h00;
    else
      cnt_ff <= (hit && cnt_ff != 5'h1F) ? cnt_ff + 5'h01 : (hit ? cnt_ff : 5'h00);
  end
  assign ardy = rdy && !useSync;
  assign srdy = rdy && useSync;
endmodule // csw_mem_model

// file: test_chip_select_wait_state_unit.sv
// Purpose: self-checking bench for the select and wait-state unit
// Assumes: access length counts T1 through T4 inclusive
// Notes:   regions are kept apart so no two selects overlap
`timescale 1ns/100ps
module test_chip_select_wait_state_unit;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  regAddr = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        cycleStart = 1'b0;
  logic [19:0] cycleAddr = 20'h00000;
  logic        cycleIo = 1'b0;
  logic        cycleWrite = 1'b0;
  logic        cycleBheN = 1'b1;
  logic        pcbHit = 1'b0;
  logic        useSync = 1'b0;
  logic [4:0]  slowCyc = 5'h00;
  logic [15:0] regRdata, adAddrOut, v;
  logic [19:0] addrBus, selT1, a;
  logic [3:0]  mcsN, pcsLowN;
  logic [2:0]  c;
  logic        ardy, srdy, adAddrOe, wrN, whbN, wlbN, ucsN, lcsN, io, da, ps;
  logic        pcs5Pin, pcs6Pin, psramSel, busy, cycleDone;
  int          err_total = 0;
  int          n_tests = 0;
  int          len, k, n, w;
  always #10 mclk = ~mclk;
  csw_select_unit csw_select_unit_inst (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .cycleStart, .cycleAddr, .cycleIo, .cycleWrite, .cycleBheN, .pcbHit, .ardy,
    .srdy, .addrBus, .adAddrOut, .adAddrOe, .wrN, .whbN, .wlbN, .ucsN, .lcsN, .mcsN,
    .pcsLowN, .pcs5Pin, .pcs6Pin, .psramSel, .busy, .cycleDone);
  csw_mem_model csw_mem_model_inst (.mclk, .rst, .selN({ucsN, lcsN, mcsN, pcsLowN}),
    .slowCyc, .useSync, .ardy, .srdy);
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chkVal(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkLen(input string nm, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic wrReg(input logic [2:0] ad, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [2:0] ad, input logic [15:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chkVal("register", {4'h0, exp}, {4'h0, regRdata});
    @(posedge mclk);
    #1 chkVal("read idle", 20'h00000, {4'h0, regRdata});
  endtask
  // random write and byte enable feed the strobe properties
  task automatic acc(input logic [19:0] ad, input logic isIo, input logic on_chip_peripheral_block);
    @(posedge mclk);
    cycleStart <= 1'b1;
    cycleAddr <= ad;
    cycleIo <= isIo;
    pcbHit <= on_chip_peripheral_block;
    cycleWrite <= 1'($urandom);
    cycleBheN <= 1'($urandom);
    @(posedge mclk);
    cycleStart <= 1'b0;
    #1 selT1 = {6'h00, pcs6Pin, pcs5Pin, psramSel, adAddrOe, ucsN, lcsN, mcsN, pcsLowN};
    chkVal("addr bus", ad, addrBus);
    chkVal("muxed addr", {4'h0, ad[15:0]}, {4'h0, adAddrOut});
    len = 1;
    for (int t = 0; t < 100 && cycleDone !== 1'b1; t++) begin
      @(posedge mclk);
      #1 len++;
    end
    if (cycleDone !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask
  function automatic logic [19:0] expSel(input int i, input logic oe, ps, p5, p6);
    return {6'h00, p6, p5, ps, oe, ~(10'h200 >> i)};
  endfunction
  function automatic int xw(input logic [2:0] cd);
    int tab[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    return tab[cd];
  endfunction
  initial begin
    void'($urandom(46));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    acc(20'hFFFF0, 1'b0, 1'b0);
    chkVal("boot sel", expSel(0, 1'b1, 1'b0, 1'b1, 1'b1), selT1);
    chkLen("boot len", 7, len);
    for (k = 0; k < 2; k++) begin
      slowCyc <= 5'h06;
      useSync <= k[0];
      acc(20'hFFFF0, 1'b0, 1'b0);
      chkLen("slow len", 1, int'(len > 8 && len < 22));
    end
    slowCyc <= 5'h00;
    acc(20'h00010, 1'b0, 1'b0);
    chkVal("idle low", expSel(10, 1'b1, 1'b0, 1'b1, 1'b1), selT1);
    chkLen("miss len", 4, len);
    rdReg(csw_pkg::REG_STAT, 16'h0001);
    rdReg(csw_pkg::REG_UPPER_MEMORY_SELECT_CTRL, 16'hF007);
    wrReg(csw_pkg::REG_STAT, 16'hFFFF);
    rdReg(csw_pkg::REG_STAT, 16'h0001);
    rdReg(3'h6, 16'h0000);
    for (k = 0; k < 6; k++) begin
      w = $urandom % 4;
      da = 1'($urandom);
      ps = 1'($urandom);
      v = {4'h3, 4'h0, da, ps, 3'h0, 1'($urandom), 2'(w)};
      wrReg(csw_pkg::REG_LOW_MEMORY_SELECT_CTRL, v);
      rdReg(csw_pkg::REG_LOW_MEMORY_SELECT_CTRL, v);
      acc({2'h0, 18'($urandom)}, 1'b0, 1'b0);
      chkVal("low sel", expSel(1, !da, ps, 1'b1, 1'b1), selT1);
      chkLen("low len", 4 + w, len);
    end
    for (k = 0; k < 16; k++) begin
      n = (k < 8) ? k % 4 : k % 7;
      c = 3'(k);
      io = 1'($urandom);
      w = $urandom % 4;
      if (n == 4)
        c[2] = 1'b0;
      // one base for every peripheral select keeps the regions disjoint
      wrReg(csw_pkg::REG_PERIPHERAL_SELECT_BASE_CTRL, {9'h100, 3'h0, c[2], 1'b0, c[1:0]});
      wrReg(csw_pkg::REG_SELECT_AUXILIARY_CTRL, {8'h00, 1'b0, io, 4'h0, 2'(w)});
      acc({io ? 9'h000 : 9'h100, 3'(n), 8'($urandom)}, io, 1'b0);
      chkVal("pcs sel", expSel(n < 4 ? 9 - n : 10, 1'b1, 1'b0, n != 5, n != 6), selT1);
      chkLen("pcs len", 4 + (n < 4 ? xw(c) : (n == 4 ? int'(c[1:0]) : w)), len);
    end
    wrReg(csw_pkg::REG_SELECT_AUXILIARY_CTRL, 16'h0083);
    for (k = 0; k < 4; k++) begin
      a = {9'h100, 3'(5 + k % 2), 8'($urandom)};
      acc(a, 1'b0, 1'b0);
      chkVal("addr pins", expSel(10, 1'b1, 1'b0, a[1], a[2]), selT1);
      chkLen("addr len", 4, len);
    end
    acc({4'h4, 16'($urandom)}, 1'b0, 1'b1);
    chkLen("pcb len", 4, len);
    for (k = 0; k < 4; k++) begin
      a = {7'h30, 2'(k), 11'($urandom)};
      wrReg(csw_pkg::REG_MIDRANGE_MEMORY_SELECT_CTRL, {7'h30, 7'h00, 2'(k)});
      acc(a, 1'b0, 1'b0);
      chkVal("mid sel", expSel(5 - k, 1'b1, 1'b0, a[1], a[2]), selT1);
      chkLen("mid len", 4 + k, len);
    end
    rdReg(csw_pkg::REG_STAT, 16'h000F);
    stop_test();
  end
endmodule // test_chip_select_wait_state_unit
